// ===== verilog/rmec_pkg.sv
// package for the run-mode and output-enable controller
package rmec_pkg;
    // ========================================================
    // register map
    localparam logic [3:0]  RMEC_OFS_CONFIG  = 4'h0;
    localparam logic [3:0]  RMEC_OFS_COMMAND = 4'h4;
    localparam logic [3:0]  RMEC_OFS_STATUS  = 4'h8;
    // ========================================================
    // config fields
    localparam int          RMEC_CF_CONT      = 0;
    localparam int          RMEC_CF_GATE      = 1;
    localparam int          RMEC_CF_ARMED     = 2;
    localparam int          RMEC_CF_ENSRC     = 4;
    localparam int          RMEC_CF_EVEDGE    = 8;
    localparam int          RMEC_CF_TRGEDGE   = 12;
    localparam int          RMEC_CF_TRGREMOTE = 16;
    localparam int          RMEC_CF_GATELOW   = 17;
    // ========================================================
    // command fields (write one to act)
    localparam int          RMEC_CMD_ENABLE   = 0;
    localparam int          RMEC_CMD_ABORT    = 1;
    localparam int          RMEC_CMD_TRIGGER  = 2;
    localparam int          RMEC_CMD_FUNCSEL  = 3;
    // ========================================================
    // status fields
    localparam int          RMEC_ST_RUN       = 0;
    localparam int          RMEC_ST_FUNC      = 1;
    localparam int          RMEC_ST_EVLVL     = 2;
    localparam int          RMEC_ST_TRGLVL    = 3;
    // ========================================================
    // encodings
    localparam logic [1:0]  RMEC_EDGE_RISE    = 2'h0;
    localparam logic [1:0]  RMEC_EDGE_FALL    = 2'h1;
    localparam logic [1:0]  RMEC_EDGE_BOTH    = 2'h2;
    localparam logic [1:0]  RMEC_SRC_BUS      = 2'h0;
    localparam logic [1:0]  RMEC_SRC_EVENT    = 2'h1;
    localparam logic [1:0]  RMEC_SRC_TRIG     = 2'h2;
    // ========================================================
    // reset values
    localparam logic        RMEC_RST_CONT     = 1'b1;
    localparam logic        RMEC_RST_GATE     = 1'b0;
    localparam logic        RMEC_RST_ARMED    = 1'b0;

    typedef struct packed {
        logic       gate_low;
        logic       trg_remote;
        logic [1:0] trg_edge;
        logic [1:0] ev_edge;
        logic [1:0] en_src;
        logic       armed;
        logic       gate;
        logic       cont;
    } rmec_cfg_t;

    typedef enum logic {RMEC_IDLE, RMEC_RUN} rmec_state_t;
endpackage : rmec_pkg

// ===== verilog/rmec_top.sv
// run-mode and output-enable controller with avalon-mm register slave
//
// Behaviour
// - Event edge selector offers rising, falling or both, and only matching edges count.
// - After reset the event edge selector is rising-edge.
// - Enable starts output at once only in continuous armed mode, never in triggered modes.
// - Abort stops generation at once, except in continuous self mode where it is ignored, and the output falls to its idle condition.
// - Continuous self mode, the reset default, runs as soon as the function is selected.
// - Continuous armed mode waits for an enable and then runs until abort.
// - Enable mode and enable source matter only in continuous mode.
// - With the gate bit at 0, continuous bit at 1, the reset default, is continuous; at 0 it selects triggered mode.
// - In triggered mode only a valid trigger starts output: the trigger input, or the remote trigger when that source is chosen.
// - With the bus source, the reset default, only remote enables count; events are ignored.
// - With the event source a valid event starts generation and remote enables are ignored.
// - With the trigger source a valid trigger starts generation; remote enables are ignored.
// - Gate bit at 1 selects gated mode, 0 by default, running only while the gate is asserted.
// - A remote trigger acts only in triggered mode with the remote trigger source.
// - Every setting reads back its active value.
// - Abort is also honoured in every triggered mode, returning the output to idle.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module rmec_top
    import rmec_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        event_in,
    input  wire logic        trig_in,
    input  wire logic        burst_done,
    output logic             wave_run,
    output logic             idle_hold,
    output logic             burst_start,
    output logic             abort_done
);
    // ========================================================
    // edge qualifier, shared by event and trigger inputs
    // code 3 matches no edge, so an input can be muted without another bit
    function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
        logic rise;
        logic fall;
        rise = cur & ~prev;
        fall = ~cur & prev;
        if (sel == RMEC_EDGE_RISE) begin
            edge_hit = rise;
        end else if (sel == RMEC_EDGE_FALL) begin
            edge_hit = fall;
        end else if (sel == RMEC_EDGE_BOTH) begin
            edge_hit = rise | fall;
        end else begin
            edge_hit = 1'b0;
        end
    endfunction : edge_hit

    // ========================================================
    // synchronisers
    logic [2:0]  ev_sync_q;
    logic [2:0]  trg_sync_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ev_sync_q  <= 3'h0;
            trg_sync_q <= 3'h0;
        end else begin
            // bit 0 only feeds bit 1; edges compare bits 1 and 2
            ev_sync_q  <= {ev_sync_q[1:0], event_in};
            trg_sync_q <= {trg_sync_q[1:0], trig_in};
        end
    end

    // ========================================================
    // avalon slave
    rmec_cfg_t   cfg_q;
    logic        func_sel_q;
    logic        wait_q;
    logic [31:0] rdata_q;
    logic        acc_go;
    logic        wr_go;
    logic        cmd_enable;
    logic        cmd_abort;
    logic        cmd_trig;
    rmec_state_t state_q;
    logic [31:0] cfg_word;

    assign acc_go = (avs_read | avs_write) & ~wait_q;
    assign wr_go  = avs_write & ~wait_q;

    always_comb begin
        cfg_word                               = 32'h0;
        cfg_word[RMEC_CF_CONT]                 = cfg_q.cont;
        cfg_word[RMEC_CF_GATE]                 = cfg_q.gate;
        cfg_word[RMEC_CF_ARMED]                = cfg_q.armed;
        cfg_word[RMEC_CF_ENSRC +: 2]           = cfg_q.en_src;
        cfg_word[RMEC_CF_EVEDGE +: 2]          = cfg_q.ev_edge;
        cfg_word[RMEC_CF_TRGEDGE +: 2]         = cfg_q.trg_edge;
        cfg_word[RMEC_CF_TRGREMOTE]            = cfg_q.trg_remote;
        cfg_word[RMEC_CF_GATELOW]              = cfg_q.gate_low;
    end

    // one wait cycle, then a single low cycle for the accepting edge
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            wait_q <= 1'b1;
        end else if ((avs_read | avs_write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rdata_q <= 32'h0;
        end else if (avs_read && wait_q) begin
            if (avs_address == RMEC_OFS_CONFIG) begin
                rdata_q <= cfg_word;
            end else if (avs_address == RMEC_OFS_STATUS) begin
                rdata_q                  <= 32'h0;
                rdata_q[RMEC_ST_RUN]     <= (state_q == RMEC_RUN);
                rdata_q[RMEC_ST_FUNC]    <= func_sel_q;
                rdata_q[RMEC_ST_EVLVL]   <= ev_sync_q[2];
                rdata_q[RMEC_ST_TRGLVL]  <= trg_sync_q[2];
            end else begin
                rdata_q <= 32'h0;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q.cont       <= RMEC_RST_CONT;
            cfg_q.gate       <= RMEC_RST_GATE;
            cfg_q.armed      <= RMEC_RST_ARMED;
            cfg_q.en_src     <= RMEC_SRC_BUS;
            cfg_q.ev_edge    <= RMEC_EDGE_RISE;
            cfg_q.trg_edge   <= RMEC_EDGE_RISE;
            cfg_q.trg_remote <= 1'b0;
            cfg_q.gate_low   <= 1'b0;
        end else if (wr_go && avs_address == RMEC_OFS_CONFIG) begin
            if (avs_byteenable[0]) begin
                cfg_q.cont   <= avs_writedata[RMEC_CF_CONT];
                cfg_q.gate   <= avs_writedata[RMEC_CF_GATE];
                cfg_q.armed  <= avs_writedata[RMEC_CF_ARMED];
                cfg_q.en_src <= avs_writedata[RMEC_CF_ENSRC +: 2];
            end
            if (avs_byteenable[1]) begin
                cfg_q.ev_edge  <= avs_writedata[RMEC_CF_EVEDGE +: 2];
                cfg_q.trg_edge <= avs_writedata[RMEC_CF_TRGEDGE +: 2];
            end
            if (avs_byteenable[2]) begin
                cfg_q.trg_remote <= avs_writedata[RMEC_CF_TRGREMOTE];
                cfg_q.gate_low   <= avs_writedata[RMEC_CF_GATELOW];
            end
        end
    end

    assign cmd_enable = wr_go && avs_address == RMEC_OFS_COMMAND && avs_byteenable[0]
                        && avs_writedata[RMEC_CMD_ENABLE];
    assign cmd_abort  = wr_go && avs_address == RMEC_OFS_COMMAND && avs_byteenable[0]
                        && avs_writedata[RMEC_CMD_ABORT];
    assign cmd_trig   = wr_go && avs_address == RMEC_OFS_COMMAND && avs_byteenable[0]
                        && avs_writedata[RMEC_CMD_TRIGGER];

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            func_sel_q <= 1'b0;
        end else if (wr_go && avs_address == RMEC_OFS_COMMAND && avs_byteenable[0]
                     && avs_writedata[RMEC_CMD_FUNCSEL]) begin
            func_sel_q <= 1'b1;
        end
    end

    // ========================================================
    // mode decode and start sources
    logic        mode_gated;
    logic        mode_trig;
    logic        mode_cont;
    logic        ev_pulse;
    logic        trg_pulse;
    logic        gate_lvl;
    logic        enable_hit;
    logic        trig_fire;
    logic        abort_hit;

    assign mode_gated = cfg_q.gate;
    assign mode_trig  = ~cfg_q.gate & ~cfg_q.cont;
    assign mode_cont  = ~cfg_q.gate & cfg_q.cont;
    assign ev_pulse   = edge_hit(cfg_q.ev_edge, ev_sync_q[1], ev_sync_q[2]);
    assign trg_pulse  = edge_hit(cfg_q.trg_edge, trg_sync_q[1], trg_sync_q[2]);
    assign gate_lvl   = trg_sync_q[1] ^ cfg_q.gate_low;

    // only the chosen source may enable; others are dropped
    always_comb begin
        if (cfg_q.en_src == RMEC_SRC_BUS) begin
            enable_hit = cmd_enable;
        end else if (cfg_q.en_src == RMEC_SRC_EVENT) begin
            enable_hit = ev_pulse;
        end else if (cfg_q.en_src == RMEC_SRC_TRIG) begin
            enable_hit = trg_pulse;
        end else begin
            enable_hit = 1'b0;
        end
    end

    // remote trigger stands in for the input only when chosen
    assign trig_fire = mode_trig & (cfg_q.trg_remote ? cmd_trig : trg_pulse);
    // self mode has nothing armed to abort
    assign abort_hit = cmd_abort & ~(mode_cont & ~cfg_q.armed);

    // ========================================================
    // run state
    rmec_state_t state_d;

    // burst_done only ends triggered runs; continuous runs ignore it
    always_comb begin
        state_d = state_q;
        if (mode_gated) begin
            state_d = (gate_lvl && !abort_hit) ? RMEC_RUN : RMEC_IDLE;
        end else if (mode_trig) begin
            if (abort_hit || (state_q == RMEC_RUN && burst_done)) begin
                state_d = RMEC_IDLE;
            end else if (trig_fire) begin
                state_d = RMEC_RUN;
            end
        end else if (!cfg_q.armed) begin
            state_d = func_sel_q ? RMEC_RUN : RMEC_IDLE;
        end else if (abort_hit) begin
            state_d = RMEC_IDLE;
        end else if (enable_hit) begin
            state_d = RMEC_RUN;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= RMEC_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    logic        run_q;
    logic        idle_q;
    logic        burst_q;
    logic        abort_q;

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            run_q   <= 1'b0;
            idle_q  <= 1'b1;
            burst_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            run_q   <= (state_d == RMEC_RUN);
            idle_q  <= (state_d != RMEC_RUN);
            burst_q <= trig_fire & ~abort_hit;
            abort_q <= abort_hit;
        end
    end

    assign wave_run        = run_q;
    assign idle_hold       = idle_q;
    assign burst_start     = burst_q;
    assign abort_done      = abort_q;
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // ========================================================
    // checks
    a_edge_filter_fall: assert property (@(posedge clock) disable iff (!rst_b)
        (cfg_q.ev_edge == RMEC_EDGE_FALL && ev_sync_q[1] && !ev_sync_q[2]) |-> !ev_pulse)
        else $error("rising event edge accepted with falling selection");
    a_edge_reset_rise: assert property (@(posedge clock)
        $rose(rst_b) |-> cfg_q.ev_edge == RMEC_EDGE_RISE)
        else $error("event edge not rising after reset");
    a_enable_starts_run: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_cont && cfg_q.armed && cfg_q.en_src == RMEC_SRC_BUS && cmd_enable && !cmd_abort)
        |=> wave_run ##1 wave_run)
        else $error("enable did not start armed output");
    a_abort_to_idle: assert property (@(posedge clock) disable iff (!rst_b)
        abort_hit |=> !wave_run && idle_hold && abort_done)
        else $error("abort did not stop output");
    a_self_mode_runs: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_cont && !cfg_q.armed && func_sel_q) |=> wave_run)
        else $error("self mode did not run");
    a_armed_holds_off: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_cont && cfg_q.armed && state_q == RMEC_IDLE && !enable_hit) |=> !wave_run)
        else $error("armed mode ran without enable");
    a_enable_ignored_trig: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_trig && !trig_fire && !abort_hit && !burst_done) |=> $stable(state_q))
        else $error("triggered mode started without trigger");
    a_bus_ignores_event: assert property (@(posedge clock) disable iff (!rst_b)
        (cfg_q.en_src == RMEC_SRC_BUS && ev_pulse && !cmd_enable) |-> !enable_hit)
        else $error("event enabled bus source");
    a_event_starts_run: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_cont && cfg_q.armed && cfg_q.en_src == RMEC_SRC_EVENT && !cmd_abort)
        |-> (enable_hit == ev_pulse))
        else $error("event source enable mismatch");
    a_trig_src_start: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_cont && cfg_q.armed && cfg_q.en_src == RMEC_SRC_TRIG && trg_pulse && !cmd_abort)
        |=> wave_run)
        else $error("trigger source did not start output");
    a_gate_follows_lvl: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_gated && !cmd_abort) |=> wave_run == $past(gate_lvl))
        else $error("gated output does not follow gate");
    a_remote_trig_gate: assert property (@(posedge clock) disable iff (!rst_b)
        (cmd_trig && !(mode_trig && cfg_q.trg_remote) && !(mode_trig && trg_pulse))
        |=> !burst_start)
        else $error("remote trigger acted outside its mode");
    a_config_readback: assert property (@(posedge clock) disable iff (!rst_b)
        (avs_read && wait_q && avs_address == RMEC_OFS_CONFIG && !avs_write)
        |=> avs_readdata == $past(cfg_word) && !avs_waitrequest)
        else $error("config readback mismatch");
    a_edge_filter_rise: assert property (@(posedge clock) disable iff (!rst_b)
        (cfg_q.ev_edge == RMEC_EDGE_RISE && !ev_sync_q[1] && ev_sync_q[2]) |-> !ev_pulse)
        else $error("falling event edge accepted with rising selection");
    a_edge_both_pass: assert property (@(posedge clock) disable iff (!rst_b)
        (cfg_q.ev_edge == RMEC_EDGE_BOTH && ev_sync_q[1] != ev_sync_q[2]) |-> ev_pulse)
        else $error("event edge dropped with both edges selected");
    a_idle_is_inverse: assert property (@(posedge clock) disable iff (!rst_b)
        idle_hold != wave_run)
        else $error("idle flag does not mirror run");
    a_abort_trig_mode: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_trig && cmd_abort) |=> !wave_run && abort_done)
        else $error("abort ignored in triggered mode");
    a_trig_starts_run: assert property (@(posedge clock) disable iff (!rst_b)
        (trig_fire && !abort_hit && !burst_done) |=> wave_run && burst_start)
        else $error("valid trigger did not start a burst");
    a_burst_only_trig: assert property (@(posedge clock) disable iff (!rst_b)
        burst_start |-> $past(mode_trig))
        else $error("burst started outside triggered mode");
    a_trig_mode_waits: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_trig && state_q == RMEC_IDLE && !trig_fire) |=> !wave_run)
        else $error("enable source acted in triggered mode");
    a_remote_trig_runs: assert property (@(posedge clock) disable iff (!rst_b)
        (mode_trig && cfg_q.trg_remote && cmd_trig && !cmd_abort && !burst_done)
        |=> wave_run && burst_start)
        else $error("remote trigger did not start a burst");
    a_sync_two_stage: assert property (@(posedge clock) disable iff (!rst_b)
        $rose(ev_sync_q[1]) |-> $past(event_in, 2))
        else $error("event synchroniser depth wrong");
endmodule : rmec_top

// ===== verification/rmec_src_model.sv
// far-side model: event source, trigger source and downstream burst counter
`timescale 1ns/1ps
module rmec_src_model (
    input  wire logic clock,
    output logic      event_in,
    output logic      trig_in,
    output logic      burst_done
);
    // ========================================================
    // pin drivers, changed only just after a rising edge
    initial begin
        event_in   = 1'b0;
        trig_in    = 1'b0;
        burst_done = 1'b0;
    end

    task automatic ev_set(input logic v);
        @(posedge clock);
        event_in <= v;
    endtask : ev_set

    task automatic tr_set(input logic v);
        @(posedge clock);
        trig_in <= v;
    endtask : tr_set

    // burst counter reports completion for exactly one cycle
    task automatic burst_pulse();
        @(posedge clock);
        burst_done <= 1'b1;
        @(posedge clock);
        burst_done <= 1'b0;
    endtask : burst_pulse
endmodule : rmec_src_model

// ===== verification/tb.sv
// self-checking bench for the run-mode and output-enable controller
`timescale 1ns/1ps
module tb;
    import rmec_pkg::*;
    logic        clock;
    logic        rst_b;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        event_in;
    logic        trig_in;
    logic        burst_done;
    logic        wave_run;
    logic        idle_hold;
    logic        burst_start;
    logic        abort_done;
    int          err_total;
    int          n_checks;
    int          n_abort;
    int          n_burst;
    logic [31:0] cfg;

    // ========================================================
    // instances
    rmec_top i_dut (.clock(clock), .rst_b(rst_b), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .event_in(event_in), .trig_in(trig_in),
        .burst_done(burst_done), .wave_run(wave_run), .idle_hold(idle_hold),
        .burst_start(burst_start), .abort_done(abort_done));
    rmec_src_model i_src (.clock(clock), .event_in(event_in), .trig_in(trig_in),
        .burst_done(burst_done));

    // ========================================================
    // clock and pulse monitors
    initial clock = 1'b0;
    always #4 clock = ~clock;
    always @(posedge clock) begin
        if (abort_done === 1'b1) n_abort++;
        if (burst_start === 1'b1) n_burst++;
    end

    // ========================================================
    // reporting
    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : stop_test

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: %s got %b expected %b", $time, m, got, exp);
        end
    endtask : chk_bit

    // ========================================================
    // avalon master: hold request until waitrequest is sampled low
    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           input logic [3:0] be, output logic [31:0] q);
        int n;
        n = 0;
        q = 32'h0;
        @(posedge clock);
        avs_address    <= a;
        avs_write      <= wr;
        avs_read       <= ~wr;
        avs_writedata  <= d;
        avs_byteenable <= be;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            $display("mismatch at %0t: bus access never answered", $time);
            stop_test();
        end else begin
            q = avs_readdata;
            avs_read  <= 1'b0;
            avs_write <= 1'b0;
        end
    endtask : av_xfer

    task automatic av_wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        av_xfer(1'b1, a, d, 4'hF, q);
    endtask : av_wr

    task automatic av_wr_be(input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        logic [31:0] q;
        av_xfer(1'b1, a, d, be, q);
    endtask : av_wr_be

    task automatic av_rd(input logic [3:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av_xfer(1'b0, a, 32'h0, 4'hF, q);
        chk_word(q, exp, "register read");
    endtask : av_rd

    // input path needs up to three edges, so six leaves margin
    task automatic check_run(input logic exp);
        repeat (6) @(posedge clock);
        chk_bit(wave_run, exp, "wave_run");
        chk_bit(idle_hold, ~exp, "idle_hold");
    endtask : check_run

    // ========================================================
    // main sequence
    initial begin
        rst_b = 1'b0; avs_address = 4'h0; avs_read = 1'b0; avs_write = 1'b0;
        avs_writedata = 32'h0; avs_byteenable = 4'hF;
        err_total = 0; n_checks = 0; n_abort = 0; n_burst = 0;
        repeat (6) @(posedge clock);
        check_run(1'b0);
        rst_b <= 1'b1;
        av_rd(RMEC_OFS_CONFIG, 32'h0000_0001);
        av_rd(4'hC, 32'h0000_0000);
        av_rd(RMEC_OFS_COMMAND, 32'h0000_0000);
        // lane 1 only: edge fields change, run-mode bits keep their values
        av_wr_be(RMEC_OFS_CONFIG, 32'h0003_3306, 4'h2);
        av_rd(RMEC_OFS_CONFIG, 32'h0000_3301);
        av_wr(RMEC_OFS_CONFIG, 32'h0000_0001);
        av_wr_be(RMEC_OFS_COMMAND, 32'h0000_0008, 4'hE);
        check_run(1'b0);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0008);
        check_run(1'b1);
        av_rd(RMEC_OFS_STATUS, 32'h0000_0003);
        // armed, bus source: events ignored, enable runs until abort
        av_wr(RMEC_OFS_CONFIG, 32'h0000_0005);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0002);
        check_run(1'b0);
        i_src.ev_set(1'b1);
        check_run(1'b0);
        i_src.ev_set(1'b0);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0001);
        check_run(1'b1);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0002);
        check_run(1'b0);
        chk_word(32'(n_abort), 32'h2, "abort pulses");
        // event source, every edge setting
        for (int e = 0; e < 4; e++) begin
            cfg = 32'h0000_0015 | (32'(e) << RMEC_CF_EVEDGE);
            av_wr(RMEC_OFS_CONFIG, cfg);
            av_rd(RMEC_OFS_CONFIG, cfg);
            av_wr(RMEC_OFS_COMMAND, 32'h0000_0001);
            check_run(1'b0);
            i_src.ev_set(1'b1);
            check_run(e == 0 || e == 2);
            av_wr(RMEC_OFS_COMMAND, 32'h0000_0002);
            i_src.ev_set(1'b0);
            check_run(e == 1 || e == 2);
            av_wr(RMEC_OFS_COMMAND, 32'h0000_0002);
            check_run(1'b0);
        end
        // trigger source
        av_wr(RMEC_OFS_CONFIG, 32'h0000_0025);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0001);
        check_run(1'b0);
        i_src.tr_set(1'b1);
        check_run(1'b1);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0002);
        i_src.tr_set(1'b0);
        check_run(1'b0);
        // triggered mode, pin source then remote source
        av_wr(RMEC_OFS_CONFIG, 32'h0000_0000);
        av_rd(RMEC_OFS_CONFIG, 32'h0000_0000);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0001);
        check_run(1'b0);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0004);
        check_run(1'b0);
        i_src.tr_set(1'b1);
        check_run(1'b1);
        chk_word(32'(n_burst), 32'h1, "burst starts");
        i_src.burst_pulse();
        check_run(1'b0);
        i_src.tr_set(1'b0);
        av_wr(RMEC_OFS_CONFIG, 32'h0001_0000);
        i_src.tr_set(1'b1);
        check_run(1'b0);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0004);
        check_run(1'b1);
        av_wr(RMEC_OFS_COMMAND, 32'h0000_0002);
        check_run(1'b0);
        // pin source on the falling edge only
        av_wr(RMEC_OFS_CONFIG, 32'h0000_1000);
        i_src.tr_set(1'b0);
        check_run(1'b1);
        chk_word(32'(n_burst), 32'h3, "burst starts");
        i_src.burst_pulse();
        check_run(1'b0);
        i_src.tr_set(1'b1);
        check_run(1'b0);
        av_wr(RMEC_OFS_CONFIG, 32'h0000_0000);
        i_src.tr_set(1'b0);
        // gated, with armed and event source set but disregarded
        av_wr(RMEC_OFS_CONFIG, 32'h0000_0017);
        check_run(1'b0);
        i_src.ev_set(1'b1);
        check_run(1'b0);
        i_src.tr_set(1'b1);
        check_run(1'b1);
        i_src.tr_set(1'b0);
        check_run(1'b0);
        av_wr(RMEC_OFS_CONFIG, 32'h0002_0002);
        check_run(1'b1);
        // reset in mid-run brings every setting back to its default
        rst_b <= 1'b0;
        check_run(1'b0);
        rst_b <= 1'b1;
        av_rd(RMEC_OFS_CONFIG, 32'h0000_0001);
        check_run(1'b0);
        stop_test();
    end

    // ========================================================
    // overall limit
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        $display("mismatch at %0t: run limit reached", $time);
        stop_test();
    end
endmodule : tb
